// [logic/sdbcs_pkg.sv]
`default_nettype none

package sdbcs_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int T_RP_NS       = 20;
    localparam int T_RCD_NS      = 20;
    localparam int T_RFC_NS      = 66;
    localparam int T_XSR_NS      = 75;
    localparam int T_MRD_CYC     = 2;

    localparam int TMR_W = 5;

    localparam logic [TMR_W-1:0] TRP_CYC  = TMR_W'((T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] TRCD_CYC = TMR_W'((T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] TRFC_CYC = TMR_W'((T_RFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] TXSR_CYC = TMR_W'((T_XSR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] TMRD_CYC = TMR_W'(T_MRD_CYC);

    // timers load count-1 so a state lasts exactly the full count
    localparam logic [TMR_W-1:0] TRP_LOAD  = TRP_CYC - 5'h01;
    localparam logic [TMR_W-1:0] TRCD_LOAD = TRCD_CYC - 5'h01;
    localparam logic [TMR_W-1:0] TRFC_LOAD = TRFC_CYC - 5'h01;
    localparam logic [TMR_W-1:0] TXSR_LOAD = TXSR_CYC - 5'h01;
    localparam logic [TMR_W-1:0] TMRD_LOAD = TMRD_CYC - 5'h01;

    localparam int NUM_BANKS = 4;

    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    // {ras_n, cas_n, we_n} with chip select low
    typedef enum logic [2:0] {
        SDBCS_OP_LMR = 3'b000,
        SDBCS_OP_REF = 3'b001,
        SDBCS_OP_PRE = 3'b010,
        SDBCS_OP_ACT = 3'b011,
        SDBCS_OP_WR  = 3'b100,
        SDBCS_OP_RD  = 3'b101,
        SDBCS_OP_BT  = 3'b110,
        SDBCS_OP_NOP = 3'b111
    } sdbcs_op_t;

    typedef enum logic [2:0] {
        BANK_IDLE       = 3'b000,
        BANK_ACTIVATING = 3'b001,
        BANK_ACTIVE     = 3'b010,
        BANK_READ       = 3'b011,
        BANK_WRITE      = 3'b100,
        BANK_READ_AP    = 3'b101,
        BANK_WRITE_AP   = 3'b110,
        BANK_PRECHARGE  = 3'b111
    } sdbcs_bank_state_t;

    typedef enum logic [2:0] {
        DEV_NORMAL   = 3'b000,
        DEV_REFRESH  = 3'b001,
        DEV_MODE_REG = 3'b010,
        DEV_PRE_ALL  = 3'b011,
        DEV_SELF_REF = 3'b100,
        DEV_SR_EXIT  = 3'b101
    } sdbcs_dev_state_t;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       cs_n;
        logic       ras_n;
        logic       cas_n;
        logic       we_n;
        logic [1:0] ba;
        logic       a10;
    } sdbcs_pins_t;

    typedef struct packed {
        logic act;
        logic rd;
        logic wr;
        logic ap;
        logic pre;
        logic stop;
        logic intr;
    } sdbcs_bank_ev_t;

    typedef struct packed {
        sdbcs_dev_state_t dev;
        logic             accept;
        logic             illegal;
    } sdbcs_status_t;

    typedef struct packed {
        sdbcs_bank_state_t st;
        logic              ap_pre;
        logic [TMR_W-1:0]  tmr;
    } sdbcs_bank_regs_t;

    localparam sdbcs_bank_regs_t BANK_RESET = '{st: BANK_IDLE, ap_pre: 1'b0, tmr: 5'h00};

    function automatic logic sdbcs_is_open(input sdbcs_bank_state_t s);
        return (s == BANK_ACTIVE) || (s == BANK_READ) || (s == BANK_WRITE);
    endfunction

endpackage

`default_nettype wire

// [logic/sdbcs_bank.sv]
`default_nettype none

module sdbcs_bank (
    input  wire logic                      clk,
    input  wire logic                      resetn,
    input  wire sdbcs_pkg::sdbcs_bank_ev_t ev,
    output var  sdbcs_pkg::sdbcs_bank_state_t state
);

    sdbcs_pkg::sdbcs_bank_regs_t q;
    sdbcs_pkg::sdbcs_bank_regs_t d;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        if (q.tmr != 5'h00) begin
            d.tmr = q.tmr - 5'h01;
        end
        case (q.st)
            sdbcs_pkg::BANK_IDLE: begin
                if (ev.act) begin
                    d.st  = sdbcs_pkg::BANK_ACTIVATING;
                    d.tmr = sdbcs_pkg::TRCD_LOAD;
                end
                // precharge to an idle bank changes nothing
            end
            sdbcs_pkg::BANK_ACTIVATING: begin
                if (q.tmr == 5'h00) begin
                    d.st = sdbcs_pkg::BANK_ACTIVE;
                end
            end
            sdbcs_pkg::BANK_ACTIVE, sdbcs_pkg::BANK_READ, sdbcs_pkg::BANK_WRITE: begin
                if (q.st != sdbcs_pkg::BANK_ACTIVE && (ev.stop || ev.intr)) begin
                    d.st = sdbcs_pkg::BANK_ACTIVE;
                end
                if (ev.rd) begin
                    d.st = ev.ap ? sdbcs_pkg::BANK_READ_AP : sdbcs_pkg::BANK_READ;
                end else if (ev.wr) begin
                    d.st = ev.ap ? sdbcs_pkg::BANK_WRITE_AP : sdbcs_pkg::BANK_WRITE;
                end else if (ev.pre) begin
                    d.st  = sdbcs_pkg::BANK_PRECHARGE;
                    d.tmr = sdbcs_pkg::TRP_LOAD;
                end
            end
            sdbcs_pkg::BANK_READ_AP, sdbcs_pkg::BANK_WRITE_AP: begin
                if (!q.ap_pre) begin
                    if (ev.stop || ev.intr) begin
                        d.ap_pre = 1'b1;
                        d.tmr    = sdbcs_pkg::TRP_LOAD;
                    end
                end else if (q.tmr == 5'h00) begin
                    d.ap_pre = 1'b0;
                    d.st     = sdbcs_pkg::BANK_IDLE;
                end
            end
            sdbcs_pkg::BANK_PRECHARGE: begin
                if (q.tmr == 5'h00) begin
                    d.st = sdbcs_pkg::BANK_IDLE;
                end
            end
            default: begin
                d = sdbcs_pkg::BANK_RESET;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= sdbcs_pkg::BANK_RESET;
        end else begin
            q <= d;
        end
    end

    assign state = q.st;

endmodule

`default_nettype wire

// [logic/sdbcs_top.sv]
`default_nettype none

module sdbcs_top (
    input  wire logic                   clk,
    input  wire logic                   resetn,
    input  wire logic                   cke,
    input  wire sdbcs_pkg::sdbcs_pins_t cmd_i,
    input  wire logic                   burst_done,
    output var  sdbcs_pkg::sdbcs_bank_state_t [3:0] bank_state,
    output var  sdbcs_pkg::sdbcs_status_t status
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        sdbcs_pkg::sdbcs_dev_state_t   dev;
        logic [sdbcs_pkg::TMR_W-1:0]   tmr;
        logic                          cke_q;
        logic [1:0]                    last_bank;
        logic                          accept;
        logic                          illegal;
    } sdbcs_top_regs_t;

    localparam sdbcs_top_regs_t TOP_RESET = '{
        dev:       sdbcs_pkg::DEV_NORMAL,
        tmr:       5'h00,
        cke_q:     1'b0,
        last_bank: 2'h0,
        accept:    1'b0,
        illegal:   1'b0
    };

    sdbcs_top_regs_t q;
    sdbcs_top_regs_t d;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    sdbcs_pkg::sdbcs_op_t         op;
    sdbcs_pkg::sdbcs_bank_state_t tgt;
    sdbcs_pkg::sdbcs_bank_state_t last_st;
    logic                         all_idle;
    logic                         all_pre_ok;
    logic                         selected;
    logic                         live;
    logic                         busy_cmd;
    logic                         sr_entry;
    logic                         legal;
    logic                         ok;
    logic [3:0]                   idle_vec;
    logic [3:0]                   pre_ok_vec;

    assign op       = sdbcs_pkg::sdbcs_op_t'({cmd_i.ras_n, cmd_i.cas_n, cmd_i.we_n});
    assign tgt      = bank_state[cmd_i.ba];
    assign last_st  = bank_state[q.last_bank];
    assign selected = !cmd_i.cs_n && (op != sdbcs_pkg::SDBCS_OP_NOP);

    // executable only with clock enable high on both edges
    assign live = selected && q.cke_q && cke && (q.dev == sdbcs_pkg::DEV_NORMAL);

    // anything executable in a timed device state is refused
    assign busy_cmd = selected && cke && (q.dev != sdbcs_pkg::DEV_NORMAL)
                      && (q.dev != sdbcs_pkg::DEV_SELF_REF);

    assign sr_entry = !cmd_i.cs_n && (op == sdbcs_pkg::SDBCS_OP_REF) && q.cke_q && !cke
                      && (q.dev == sdbcs_pkg::DEV_NORMAL) && all_idle;

    assign all_idle   = &idle_vec;
    assign all_pre_ok = &pre_ok_vec;

    always_comb begin
        case (op)
            sdbcs_pkg::SDBCS_OP_ACT: legal = (tgt == sdbcs_pkg::BANK_IDLE);
            sdbcs_pkg::SDBCS_OP_RD,
            sdbcs_pkg::SDBCS_OP_WR:  legal = sdbcs_pkg::sdbcs_is_open(tgt);
            sdbcs_pkg::SDBCS_OP_PRE: legal = cmd_i.a10 ? all_pre_ok :
                                             (sdbcs_pkg::sdbcs_is_open(tgt) ||
                                              tgt == sdbcs_pkg::BANK_IDLE);
            sdbcs_pkg::SDBCS_OP_REF,
            sdbcs_pkg::SDBCS_OP_LMR: legal = all_idle;
            sdbcs_pkg::SDBCS_OP_BT:  legal = (last_st == sdbcs_pkg::BANK_READ) ||
                                             (last_st == sdbcs_pkg::BANK_WRITE);
            default:                 legal = 1'b0;
        endcase
    end

    assign ok = live && legal;

    // ------------------------------------------------------------
    // banks
    // ------------------------------------------------------------
    sdbcs_pkg::sdbcs_bank_ev_t ev [sdbcs_pkg::NUM_BANKS];

    for (genvar i = 0; i < sdbcs_pkg::NUM_BANKS; i++) begin : g_bank
        logic hit;
        assign hit           = (cmd_i.ba == 2'(i));
        assign idle_vec[i]   = (bank_state[i] == sdbcs_pkg::BANK_IDLE);
        assign pre_ok_vec[i] = idle_vec[i] || sdbcs_pkg::sdbcs_is_open(bank_state[i]);
        assign ev[i].act  = ok && hit && (op == sdbcs_pkg::SDBCS_OP_ACT);
        assign ev[i].rd   = ok && hit && (op == sdbcs_pkg::SDBCS_OP_RD);
        assign ev[i].wr   = ok && hit && (op == sdbcs_pkg::SDBCS_OP_WR);
        assign ev[i].ap   = cmd_i.a10;
        assign ev[i].pre  = ok && (op == sdbcs_pkg::SDBCS_OP_PRE) && (hit || cmd_i.a10);
        // most recent burst ends by terminate or by its own end
        assign ev[i].stop = (q.last_bank == 2'(i)) &&
                            ((ok && op == sdbcs_pkg::SDBCS_OP_BT) || burst_done);
        // a burst started in another bank interrupts this one
        assign ev[i].intr = ok && !hit &&
                            (op == sdbcs_pkg::SDBCS_OP_RD || op == sdbcs_pkg::SDBCS_OP_WR);

        sdbcs_bank u_bank (
            .clk    (clk),
            .resetn (resetn),
            .ev     (ev[i]),
            .state  (bank_state[i])
        );
    end

    // ------------------------------------------------------------
    // device state and shared timer
    // ------------------------------------------------------------
    always_comb begin
        d         = q;
        d.cke_q   = cke;
        d.accept  = ok;
        d.illegal = (live && !legal) || busy_cmd;
        if (q.tmr != 5'h00) begin
            d.tmr = q.tmr - 5'h01;
        end
        if (ok && (op == sdbcs_pkg::SDBCS_OP_RD || op == sdbcs_pkg::SDBCS_OP_WR)) begin
            d.last_bank = cmd_i.ba;
        end
        case (q.dev)
            sdbcs_pkg::DEV_NORMAL: begin
                if (sr_entry) begin
                    d.dev = sdbcs_pkg::DEV_SELF_REF;
                end else if (ok && op == sdbcs_pkg::SDBCS_OP_REF) begin
                    d.dev = sdbcs_pkg::DEV_REFRESH;
                    d.tmr = sdbcs_pkg::TRFC_LOAD;
                end else if (ok && op == sdbcs_pkg::SDBCS_OP_LMR) begin
                    d.dev = sdbcs_pkg::DEV_MODE_REG;
                    d.tmr = sdbcs_pkg::TMRD_LOAD;
                end else if (ok && op == sdbcs_pkg::SDBCS_OP_PRE && cmd_i.a10) begin
                    d.dev = sdbcs_pkg::DEV_PRE_ALL;
                    d.tmr = sdbcs_pkg::TRP_LOAD;
                end
            end
            sdbcs_pkg::DEV_REFRESH, sdbcs_pkg::DEV_MODE_REG,
            sdbcs_pkg::DEV_PRE_ALL, sdbcs_pkg::DEV_SR_EXIT: begin
                if (q.tmr == 5'h00) begin
                    d.dev = sdbcs_pkg::DEV_NORMAL;
                end
            end
            sdbcs_pkg::DEV_SELF_REF: begin
                if (cke) begin
                    d.dev = sdbcs_pkg::DEV_SR_EXIT;
                    d.tmr = sdbcs_pkg::TXSR_LOAD;
                end
            end
            default: begin
                d.dev = sdbcs_pkg::DEV_NORMAL;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= TOP_RESET;
        end else begin
            q <= d;
        end
    end

    assign status = '{dev: q.dev, accept: q.accept, illegal: q.illegal};

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking

    default disable iff (!resetn);

    sequence s_live_op(sdbcs_pkg::sdbcs_op_t o);
        live && op == o;
    endsequence

    sequence s_enter_activating;
        bank_state[0] == sdbcs_pkg::BANK_ACTIVATING &&
        $past(bank_state[0]) != sdbcs_pkg::BANK_ACTIVATING;
    endsequence

    sequence s_activating_span;
        (bank_state[0] == sdbcs_pkg::BANK_ACTIVATING) [*5]
        ##1 bank_state[0] == sdbcs_pkg::BANK_ACTIVE;
    endsequence

    sequence s_enter_refresh;
        status.dev == sdbcs_pkg::DEV_REFRESH && $past(status.dev) == sdbcs_pkg::DEV_NORMAL;
    endsequence

    sequence s_enter_pre_all;
        status.dev == sdbcs_pkg::DEV_PRE_ALL && $past(status.dev) != sdbcs_pkg::DEV_PRE_ALL;
    endsequence

    sequence s_enter_mode;
        status.dev == sdbcs_pkg::DEV_MODE_REG && $past(status.dev) != sdbcs_pkg::DEV_MODE_REG;
    endsequence

    AST_PRE_ALL_SPAN: assert property (
        s_enter_pre_all |-> (status.dev == sdbcs_pkg::DEV_PRE_ALL) [*5]
        ##1 status.dev == sdbcs_pkg::DEV_NORMAL && all_idle
    ) else $error("precharge all did not last the precharge period");

    AST_MRD_SPAN: assert property (
        s_enter_mode |-> (status.dev == sdbcs_pkg::DEV_MODE_REG) [*2]
        ##1 status.dev == sdbcs_pkg::DEV_NORMAL
    ) else $error("mode register access did not last the mode delay");

    AST_SR_EXIT_QUIET: assert property (
        (q.dev == sdbcs_pkg::DEV_SR_EXIT) |=> !status.accept
    ) else $error("command accepted before self refresh exit time");

    AST_NOP_NO_ACCEPT: assert property (
        (cmd_i.cs_n || op == sdbcs_pkg::SDBCS_OP_NOP) |=> !status.accept && !status.illegal
    ) else $error("inhibit or nop was registered as a command");

    AST_ACT_OPENS: assert property (
        s_live_op(sdbcs_pkg::SDBCS_OP_ACT) and (tgt == sdbcs_pkg::BANK_IDLE)
        |=> bank_state[$past(cmd_i.ba)] == sdbcs_pkg::BANK_ACTIVATING && status.accept
    ) else $error("active to idle bank did not start activating");

    AST_REF_NEEDS_IDLE: assert property (
        s_live_op(sdbcs_pkg::SDBCS_OP_REF) and !all_idle
        |=> status.illegal && status.dev == sdbcs_pkg::DEV_NORMAL
    ) else $error("refresh accepted with a bank not idle");

    AST_PRE_IDLE_NOP: assert property (
        s_live_op(sdbcs_pkg::SDBCS_OP_PRE) and !cmd_i.a10 and (tgt == sdbcs_pkg::BANK_IDLE)
        |=> bank_state[$past(cmd_i.ba)] == sdbcs_pkg::BANK_IDLE
    ) else $error("precharge changed an idle bank");

    AST_RD_AP_SELECT: assert property (
        s_live_op(sdbcs_pkg::SDBCS_OP_RD) and sdbcs_pkg::sdbcs_is_open(tgt)
        |=> bank_state[$past(cmd_i.ba)] == ($past(cmd_i.a10) ? sdbcs_pkg::BANK_READ_AP
                                                              : sdbcs_pkg::BANK_READ)
    ) else $error("read did not start the right burst kind");

    AST_PRE_CLOSES: assert property (
        s_live_op(sdbcs_pkg::SDBCS_OP_PRE) and !cmd_i.a10 and sdbcs_pkg::sdbcs_is_open(tgt)
        |=> bank_state[$past(cmd_i.ba)] == sdbcs_pkg::BANK_PRECHARGE
        ##5 bank_state[$past(cmd_i.ba, 6)] == sdbcs_pkg::BANK_IDLE
    ) else $error("precharge did not close the row in time");

    AST_RCD_SPAN: assert property (
        s_enter_activating |-> s_activating_span
    ) else $error("activating state did not last the activate delay");

    AST_REF_SPAN: assert property (
        s_enter_refresh |-> (status.dev == sdbcs_pkg::DEV_REFRESH) [*8]
        ##10 status.dev == sdbcs_pkg::DEV_NORMAL && all_idle
    ) else $error("refresh did not last the refresh cycle time");

    AST_BUSY_REFUSED: assert property (
        busy_cmd |=> status.illegal && !status.accept
    ) else $error("command accepted during a timed device state");

    AST_BT_STOPS: assert property (
        s_live_op(sdbcs_pkg::SDBCS_OP_BT) and legal and !burst_done
        |=> bank_state[$past(q.last_bank)] == sdbcs_pkg::BANK_ACTIVE
    ) else $error("burst terminate did not end the last burst");

    AST_CKE_GATE: assert property (
        (!q.cke_q || !cke) |=> !status.accept
    ) else $error("command accepted without clock enable held high");

endmodule

`default_nettype wire

// [tb/sdbcs_ctl_model.sv]
`default_nettype none

module sdbcs_ctl_model (
    input  wire logic                   clk,
    output var  sdbcs_pkg::sdbcs_pins_t cmd,
    output var  logic                   cke,
    output var  logic                   burst_done
);
    timeunit 1ns;
    timeprecision 1ps;

    sdbcs_pkg::sdbcs_pins_t req;
    logic                   req_pend;
    logic                   req_cke;
    logic                   done_pend;
    logic                   idle_cke;
    logic [2:0]             pat;

    initial begin
        cmd = 7'h7f;
        cke = 1'b1;
        burst_done = 1'b0;
        req = 7'h7f;
        req_pend = 1'b0;
        req_cke = 1'b1;
        done_pend = 1'b0;
        idle_cke = 1'b1;
        pat = 3'h0;
    end

    // ------------------------------------------------------------
    // pin driver
    // ------------------------------------------------------------
    always @(posedge clk) begin
        pat <= pat + 3'h1;
        burst_done <= done_pend;
        done_pend <= 1'b0;
        if (req_pend) begin
            cmd <= req;
            cke <= req_cke;
            req_pend <= 1'b0;
        end else begin
            // idle: nop or deselect, don't-care lines keep moving
            cmd <= {pat[0], pat[0] ? ~pat : 3'h7, ~cmd.ba, ~cmd.a10};
            cke <= idle_cke;
        end
    end

    // returns 1 ns after the edge that takes the command
    task issue(input sdbcs_pkg::sdbcs_op_t op, input logic [1:0] ba, input logic a10,
               input logic ck);
        req = {1'b0, op, ba, a10};
        req_cke = ck;
        req_pend = 1'b1;
        @(posedge clk);
        @(posedge clk);
        #1;
    endtask

    task done();
        done_pend = 1'b1;
        @(posedge clk);
        @(posedge clk);
        #1;
    endtask
endmodule

`default_nettype wire

// [tb/tb_top.sv]
`default_nettype none

`define CHK(nm, e, g) begin \
    n_compared++; \
    if ((e) !== (g)) begin \
        errors++; \
        $display("MISMATCH %s expected %0h seen %0h", nm, e, g); \
    end \
end

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic                               clk;
    logic                               resetn;
    logic                               cke;
    logic                               burst_done;
    int                                 errors;
    int                                 n_compared;
    sdbcs_pkg::sdbcs_pins_t             cmd_i;
    sdbcs_pkg::sdbcs_bank_state_t [3:0] bank_state;
    sdbcs_pkg::sdbcs_status_t           status;

    sdbcs_ctl_model ctl_u (.clk(clk), .cmd(cmd_i), .cke(cke), .burst_done(burst_done));

    sdbcs_top dut_u (
        .clk       (clk),
        .resetn    (resetn),
        .cke       (cke),
        .cmd_i     (cmd_i),
        .burst_done(burst_done),
        .bank_state(bank_state),
        .status    (status)
    );

    always #2 clk = ~clk;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [2:0] cur(input int b);
        return (b < 0) ? status.dev : bank_state[b];
    endfunction

    task hold(input int b, input logic [2:0] s, input int n, input logic [2:0] nx);
        for (int i = 0; i < n; i++) begin
            `CHK("state", s, cur(b))
            @(posedge clk);
            #1;
        end
        `CHK("state", nx, cur(b))
    endtask

    task cmd(input sdbcs_pkg::sdbcs_op_t op, input int b, input logic a10,
             input logic [1:0] ai, input logic [2:0] st);
        ctl_u.issue(op, 2'(b), a10, 1'b1);
        `CHK("accept", ai[1], status.accept)
        `CHK("illegal", ai[0], status.illegal)
        `CHK("bank", st, bank_state[b])
    endtask

    task t_act(input int b);
        cmd(sdbcs_pkg::SDBCS_OP_ACT, b, 1'b0, 2'b10, sdbcs_pkg::BANK_ACTIVATING);
        hold(b, sdbcs_pkg::BANK_ACTIVATING, sdbcs_pkg::TRCD_CYC, sdbcs_pkg::BANK_ACTIVE);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task s_rw;
        t_act(0);
        cmd(sdbcs_pkg::SDBCS_OP_RD, 0, 1'b0, 2'b10, sdbcs_pkg::BANK_READ);
        cmd(sdbcs_pkg::SDBCS_OP_WR, 0, 1'b0, 2'b10, sdbcs_pkg::BANK_WRITE);
        cmd(sdbcs_pkg::SDBCS_OP_WR, 0, 1'b0, 2'b10, sdbcs_pkg::BANK_WRITE);
        cmd(sdbcs_pkg::SDBCS_OP_RD, 0, 1'b0, 2'b10, sdbcs_pkg::BANK_READ);
        cmd(sdbcs_pkg::SDBCS_OP_PRE, 0, 1'b0, 2'b10, sdbcs_pkg::BANK_PRECHARGE);
        hold(0, sdbcs_pkg::BANK_PRECHARGE, sdbcs_pkg::TRP_CYC, sdbcs_pkg::BANK_IDLE);
        t_act(0);
        cmd(sdbcs_pkg::SDBCS_OP_WR, 0, 1'b0, 2'b10, sdbcs_pkg::BANK_WRITE);
        cmd(sdbcs_pkg::SDBCS_OP_PRE, 0, 1'b0, 2'b10, sdbcs_pkg::BANK_PRECHARGE);
        hold(0, sdbcs_pkg::BANK_PRECHARGE, sdbcs_pkg::TRP_CYC, sdbcs_pkg::BANK_IDLE);
    endtask

    task s_pre_idle;
        cmd(sdbcs_pkg::SDBCS_OP_PRE, 1, 1'b0, 2'b10, sdbcs_pkg::BANK_IDLE);
        cmd(sdbcs_pkg::SDBCS_OP_ACT, 1, 1'b0, 2'b10, sdbcs_pkg::BANK_ACTIVATING);
        cmd(sdbcs_pkg::SDBCS_OP_ACT, 1, 1'b0, 2'b01, sdbcs_pkg::BANK_ACTIVATING);
        hold(1, sdbcs_pkg::BANK_ACTIVATING, sdbcs_pkg::TRCD_CYC - 2, sdbcs_pkg::BANK_ACTIVE);
        cmd(sdbcs_pkg::SDBCS_OP_PRE, 1, 1'b0, 2'b10, sdbcs_pkg::BANK_PRECHARGE);
        hold(1, sdbcs_pkg::BANK_PRECHARGE, sdbcs_pkg::TRP_CYC, sdbcs_pkg::BANK_IDLE);
    endtask

    task s_ap;
        logic [2:0]           ap;
        sdbcs_pkg::sdbcs_op_t op;
        for (int k = 0; k < 2; k++) begin
            ap = k ? sdbcs_pkg::BANK_WRITE_AP : sdbcs_pkg::BANK_READ_AP;
            op = k ? sdbcs_pkg::SDBCS_OP_WR : sdbcs_pkg::SDBCS_OP_RD;
            t_act(2);
            cmd(op, 2, 1'b1, 2'b10, ap);
            cmd(sdbcs_pkg::SDBCS_OP_RD, 2, 1'b0, 2'b01, ap);
            ctl_u.done();
            hold(2, ap, sdbcs_pkg::TRP_CYC, sdbcs_pkg::BANK_IDLE);
        end
    endtask

    task s_bt;
        t_act(0);
        t_act(1);
        cmd(sdbcs_pkg::SDBCS_OP_RD, 1, 1'b0, 2'b10, sdbcs_pkg::BANK_READ);
        cmd(sdbcs_pkg::SDBCS_OP_WR, 0, 1'b0, 2'b10, sdbcs_pkg::BANK_WRITE);
        cmd(sdbcs_pkg::SDBCS_OP_BT, 1, 1'b0, 2'b10, sdbcs_pkg::BANK_ACTIVE);
        `CHK("bank0", sdbcs_pkg::BANK_ACTIVE, bank_state[0])
        cmd(sdbcs_pkg::SDBCS_OP_BT, 1, 1'b0, 2'b01, sdbcs_pkg::BANK_ACTIVE);
        cmd(sdbcs_pkg::SDBCS_OP_PRE, 3, 1'b1, 2'b10, sdbcs_pkg::BANK_IDLE);
        `CHK("bank0", sdbcs_pkg::BANK_PRECHARGE, bank_state[0])
        `CHK("bank1", sdbcs_pkg::BANK_PRECHARGE, bank_state[1])
        hold(-1, sdbcs_pkg::DEV_PRE_ALL, sdbcs_pkg::TRP_CYC, sdbcs_pkg::DEV_NORMAL);
        `CHK("bank1", sdbcs_pkg::BANK_IDLE, bank_state[1])
    endtask

    task s_ref;
        t_act(3);
        cmd(sdbcs_pkg::SDBCS_OP_REF, 3, 1'b0, 2'b01, sdbcs_pkg::BANK_ACTIVE);
        cmd(sdbcs_pkg::SDBCS_OP_LMR, 3, 1'b0, 2'b01, sdbcs_pkg::BANK_ACTIVE);
        cmd(sdbcs_pkg::SDBCS_OP_PRE, 3, 1'b0, 2'b10, sdbcs_pkg::BANK_PRECHARGE);
        hold(3, sdbcs_pkg::BANK_PRECHARGE, sdbcs_pkg::TRP_CYC, sdbcs_pkg::BANK_IDLE);
        cmd(sdbcs_pkg::SDBCS_OP_REF, 0, 1'b0, 2'b10, sdbcs_pkg::BANK_IDLE);
        cmd(sdbcs_pkg::SDBCS_OP_ACT, 1, 1'b0, 2'b01, sdbcs_pkg::BANK_IDLE);
        hold(-1, sdbcs_pkg::DEV_REFRESH, sdbcs_pkg::TRFC_CYC - 2, sdbcs_pkg::DEV_NORMAL);
        cmd(sdbcs_pkg::SDBCS_OP_LMR, 0, 1'b0, 2'b10, sdbcs_pkg::BANK_IDLE);
        hold(-1, sdbcs_pkg::DEV_MODE_REG, sdbcs_pkg::TMRD_CYC, sdbcs_pkg::DEV_NORMAL);
    endtask

    task s_cke;
        ctl_u.idle_cke = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        ctl_u.idle_cke = 1'b1;
        cmd(sdbcs_pkg::SDBCS_OP_ACT, 2, 1'b0, 2'b00, sdbcs_pkg::BANK_IDLE);
        ctl_u.issue(sdbcs_pkg::SDBCS_OP_ACT, 2'h2, 1'b0, 1'b0);
        `CHK("accept", 1'b0, status.accept)
        `CHK("bank2", sdbcs_pkg::BANK_IDLE, bank_state[2])
    endtask

    task s_sr;
        ctl_u.issue(sdbcs_pkg::SDBCS_OP_REF, 2'h0, 1'b0, 1'b0);
        `CHK("dev", sdbcs_pkg::DEV_SELF_REF, status.dev)
        @(posedge clk);
        #1;
        hold(-1, sdbcs_pkg::DEV_SR_EXIT, sdbcs_pkg::TXSR_CYC, sdbcs_pkg::DEV_NORMAL);
    endtask

    task results;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        $display("MISMATCH watchdog expected end seen hang");
        results();
    end

    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        errors = 0;
        n_compared = 0;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        s_rw();
        s_pre_idle();
        s_ap();
        s_bt();
        s_ref();
        s_cke();
        s_sr();
        results();
    end
endmodule

`default_nettype wire
